// *** logic/temp_conv_pkg.sv ***
// Shared constants and state types for the two-channel temperature conversion controller.
// Assumes a 32-bit Avalon-MM register slave with one register per aligned word.
package temp_conv_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [5:0] OFS_REMOTE = 6'h00;
  localparam logic [5:0] OFS_LOCAL = 6'h04;
  localparam logic [5:0] OFS_STATUS = 6'h08;
  localparam logic [5:0] OFS_CONFIG = 6'h0C;
  localparam logic [5:0] OFS_RATE = 6'h10;
  localparam logic [5:0] OFS_ONESHOT = 6'h14;
  localparam logic [5:0] OFS_REMOTE_HIGH = 6'h18;
  localparam logic [5:0] OFS_REMOTE_LOW = 6'h1C;
  localparam logic [5:0] OFS_LOCAL_HIGH = 6'h20;
  localparam logic [5:0] OFS_LOCAL_LOW = 6'h24;
  localparam logic [5:0] OFS_ADDRESS = 6'h28;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_BUSY = 7;
  localparam int BIT_REMOTE_HIGH = 4;
  localparam int BIT_REMOTE_LOW = 3;
  localparam int BIT_LOCAL_HIGH = 2;
  localparam int BIT_LOCAL_LOW = 1;
  localparam int BIT_HALT = 6;
  localparam int RATE_WIDTH = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_HIGH_LIMIT = 8'h7F;
  localparam logic [7:0] RST_LOW_LIMIT = 8'h80;
  localparam logic [7:0] RST_TEMP = 8'h00;
  localparam logic [2:0] RST_RATE = 3'h2;
  // Base target address; the value is arbitrary.
  localparam logic [6:0] TARGET_ADDR_BASE = 7'h18;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 50_000_000;
  localparam int CHANNEL_MS = 60;
  localparam int CONV_TOTAL_MS = 125;
  localparam longint CONV_TOTAL_CYC = longint'(CONV_TOTAL_MS) * CLK_HZ / 1000;
  // Each channel phase gets half the two-channel time, so the 60 ms integration fits inside.
  localparam longint CHANNEL_CYC = CONV_TOTAL_CYC / 2;
  localparam longint INTEGRATE_CYC = longint'(CHANNEL_MS) * CLK_HZ / 1000;
  localparam int ADDR_SETTLE = 4;

  typedef enum logic [1:0] {
    CONV_IDLE = 2'b00,
    CONV_REMOTE = 2'b01,
    CONV_LOCAL = 2'b10
  } conv_state_t;

  typedef struct packed {
    conv_state_t state;
    logic [31:0] timer;
    logic [31:0] rate_cnt;
    logic [7:0] partial_remote;
    logic [7:0] remote;
    logic [7:0] local_temp;
    logic [7:0] remote_high;
    logic [7:0] remote_low;
    logic [7:0] local_high;
    logic [7:0] local_low;
    logic halt;
    logic [2:0] rate;
    logic [3:0] flags;
    logic waitrequest;
    logic [31:0] readdata;
    logic alert_oe_n;
    logic [6:0] target_addr;
    logic [2:0] addr_cnt;
    logic addr_done;
    logic adc_channel;
    logic adc_enable;
    logic data_oe_n;
  } ctrl_state_t;

endpackage

// *** logic/pin_sync.sv ***
// Three-stage synchroniser for one asynchronous pin.
// Assumes the pin may change at any time relative to mclk.
`timescale 1ns/1ns
module pin_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic pin,
  output logic level
);
  logic [2:0] stage;

  // The accepted level changes only once the second and third stages agree.
  always_ff @(posedge mclk) begin
    if (reset) begin
      stage <= {3{RESET_VAL}};
      level <= RESET_VAL;
    end else begin
      stage <= {stage[1:0], pin};
      if (stage[1] == stage[2]) begin
        level <= stage[2];
      end
    end
  end
endmodule

// *** logic/limit_compare.sv ***
// Signed comparison of one temperature result against its high and low limits.
// Assumes two's-complement 8-bit values.
`timescale 1ns/1ns
module limit_compare (
  input wire logic [7:0] value,
  input wire logic [7:0] high_limit,
  input wire logic [7:0] low_limit,
  output logic over,
  output logic under
);
  assign over = $signed(value) > $signed(high_limit);
  assign under = $signed(value) < $signed(low_limit);
endmodule

// *** logic/temp_conv_ctrl.sv ***
// Conversion sequencing, result registers and limit alarms of a two-channel temperature sensor.
// Assumes an analog front end that presents the selected channel's 8-bit result on adc_result,
// and an external serial-bus target that is not part of this block.
`timescale 1ns/1ns
module temp_conv_ctrl #(
  parameter int CHANNEL_CYCLES = int'(temp_conv_pkg::CHANNEL_CYC),
  parameter int RATE_UNIT_CYCLES = int'(temp_conv_pkg::CONV_TOTAL_CYC)
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic hw_standby_input,
  input wire logic address_select_low_pin,
  input wire logic address_select_high_pin,
  input wire logic serial_clock_line,
  input wire logic serial_data_line_in,
  output logic serial_data_line_out,
  output logic serial_data_line_oe_n,
  output logic alert_out,
  output logic alert_oe_n,
  input wire logic [7:0] adc_result,
  output logic adc_channel,
  output logic adc_enable,
  output logic [6:0] target_address
);
  import temp_conv_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic standby_pin_high;
  logic add_low_sync;
  logic add_high_sync;

  pin_sync #(.RESET_VAL(1'b1)) u_sync_standby (
    .mclk(mclk),
    .reset(reset),
    .pin(hw_standby_input),
    .level(standby_pin_high)
  );

  pin_sync #(.RESET_VAL(1'b0)) u_sync_add_low (
    .mclk(mclk),
    .reset(reset),
    .pin(address_select_low_pin),
    .level(add_low_sync)
  );

  pin_sync #(.RESET_VAL(1'b0)) u_sync_add_high (
    .mclk(mclk),
    .reset(reset),
    .pin(address_select_high_pin),
    .level(add_high_sync)
  );

  // ----------------------------------------------------------------
  // State and limit comparison
  // ----------------------------------------------------------------
  ctrl_state_t st;
  ctrl_state_t next_st;
  logic remote_over;
  logic remote_under;
  logic local_over;
  logic local_under;

  // Compare the results that are about to be stored: remote from the partial holder,
  // local straight from the converter.
  limit_compare u_cmp_remote (
    .value(st.partial_remote),
    .high_limit(st.remote_high),
    .low_limit(st.remote_low),
    .over(remote_over),
    .under(remote_under)
  );

  limit_compare u_cmp_local (
    .value(adc_result),
    .high_limit(st.local_high),
    .low_limit(st.local_low),
    .over(local_over),
    .under(local_under)
  );

  localparam logic [31:0] CHAN_LOAD = 32'(CHANNEL_CYCLES - 1);

  logic pin_standby;
  logic bus_take;
  logic do_write;
  logic status_read;
  logic halt_set;
  logic oneshot_cmd;
  logic rate_start;
  logic start_conv;
  logic abort_conv;
  logic conv_done;
  logic [3:0] flag_set;
  logic [31:0] rate_period;
  logic [31:0] rd_value;
  logic busy;

  always_comb begin
    pin_standby = ~standby_pin_high;
    busy = (st.state != CONV_IDLE);
    // A request is answered one cycle after it is first seen; the write lands at the edge that ends the answer cycle.
    bus_take = (avs_read | avs_write) & st.waitrequest;
    do_write = avs_write & ~st.waitrequest;
    status_read = avs_read & ~st.waitrequest & (avs_address == OFS_STATUS);
    halt_set = do_write & (avs_address == OFS_CONFIG) & avs_writedata[BIT_HALT] & ~st.halt;
    oneshot_cmd = do_write & (avs_address == OFS_ONESHOT);
    rate_period = RATE_UNIT_CYCLES[31:0] << st.rate;
    rate_start = ~st.halt & ~pin_standby & (st.rate_cnt == 32'h0000_0000);
    start_conv = ~busy & ((oneshot_cmd & ~pin_standby) | rate_start);
    abort_conv = busy & (pin_standby | halt_set);
    conv_done = (st.state == CONV_LOCAL) & (st.timer == 32'h0000_0000) & ~abort_conv;
    flag_set = 4'h0;
    if (conv_done) begin
      flag_set = {remote_over, remote_under, local_over, local_under};
    end

    rd_value = 32'h0000_0000;
    unique case (avs_address)
      OFS_REMOTE: rd_value[7:0] = st.remote;
      OFS_LOCAL: rd_value[7:0] = st.local_temp;
      OFS_STATUS: begin
        rd_value[BIT_BUSY] = busy;
        rd_value[BIT_REMOTE_HIGH] = st.flags[3];
        rd_value[BIT_REMOTE_LOW] = st.flags[2];
        rd_value[BIT_LOCAL_HIGH] = st.flags[1];
        rd_value[BIT_LOCAL_LOW] = st.flags[0];
      end
      OFS_CONFIG: rd_value[BIT_HALT] = st.halt;
      OFS_RATE: rd_value[RATE_WIDTH-1:0] = st.rate;
      OFS_REMOTE_HIGH: rd_value[7:0] = st.remote_high;
      OFS_REMOTE_LOW: rd_value[7:0] = st.remote_low;
      OFS_LOCAL_HIGH: rd_value[7:0] = st.local_high;
      OFS_LOCAL_LOW: rd_value[7:0] = st.local_low;
      OFS_ADDRESS: rd_value[6:0] = st.target_addr;
      default: rd_value = 32'h0000_0000;
    endcase

    next_st = st;

    // ----------------------------------------------------------------
    // Register bus slave
    // ----------------------------------------------------------------
    next_st.waitrequest = ~bus_take;
    if (bus_take) begin
      next_st.readdata = rd_value;
    end
    if (do_write) begin
      unique case (avs_address)
        OFS_CONFIG: next_st.halt = avs_writedata[BIT_HALT];
        OFS_RATE: next_st.rate = avs_writedata[RATE_WIDTH-1:0];
        OFS_REMOTE_HIGH: next_st.remote_high = avs_writedata[7:0];
        OFS_REMOTE_LOW: next_st.remote_low = avs_writedata[7:0];
        OFS_LOCAL_HIGH: next_st.local_high = avs_writedata[7:0];
        OFS_LOCAL_LOW: next_st.local_low = avs_writedata[7:0];
        default: next_st.halt = st.halt;
      endcase
    end

    // Reading status clears the alarm flags, but a new alarm in the same cycle survives.
    if (status_read) begin
      next_st.flags = flag_set;
    end else begin
      next_st.flags = st.flags | flag_set;
    end
    next_st.alert_oe_n = ~(|next_st.flags);

    // ----------------------------------------------------------------
    // Free-running rate timer
    // ----------------------------------------------------------------
    if (busy | st.halt | pin_standby) begin
      next_st.rate_cnt = rate_period;
    end else if (st.rate_cnt != 32'h0000_0000) begin
      next_st.rate_cnt = st.rate_cnt - 32'h0000_0001;
    end

    // ----------------------------------------------------------------
    // Conversion sequence
    // ----------------------------------------------------------------
    unique case (st.state)
      CONV_IDLE: begin
        if (start_conv) begin
          next_st.state = CONV_REMOTE;
          next_st.timer = CHAN_LOAD;
        end
      end
      CONV_REMOTE: begin
        if (abort_conv) begin
          next_st.state = CONV_IDLE;
        end else if (st.timer == 32'h0000_0000) begin
          next_st.partial_remote = adc_result;
          next_st.state = CONV_LOCAL;
          next_st.timer = CHAN_LOAD;
        end else begin
          next_st.timer = st.timer - 32'h0000_0001;
        end
      end
      CONV_LOCAL: begin
        if (abort_conv) begin
          next_st.state = CONV_IDLE;
        end else if (st.timer == 32'h0000_0000) begin
          next_st.remote = st.partial_remote;
          next_st.local_temp = adc_result;
          next_st.state = CONV_IDLE;
        end else begin
          next_st.timer = st.timer - 32'h0000_0001;
        end
      end
      default: next_st.state = CONV_IDLE;
    endcase

    // The converter is powered only while a conversion runs; it steers the remote diode first.
    next_st.adc_enable = (next_st.state != CONV_IDLE);
    next_st.adc_channel = (next_st.state == CONV_LOCAL);

    // ----------------------------------------------------------------
    // Address strap capture
    // ----------------------------------------------------------------
    // The synchroniser level settles four edges after reset, so the count must reach four
    // before the one and only sample, or the reset value of the level is captured instead.
    if (!st.addr_done) begin
      if (st.addr_cnt == 3'(ADDR_SETTLE)) begin
        next_st.target_addr = TARGET_ADDR_BASE | {5'h00, add_high_sync, add_low_sync};
        next_st.addr_done = 1'b1;
      end else begin
        next_st.addr_cnt = st.addr_cnt + 3'h1;
      end
    end

    // The serial data driver stays released; framing lives outside this block.
    next_st.data_oe_n = 1'b1;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      st <= '{
        state: CONV_IDLE,
        timer: 32'h0000_0000,
        rate_cnt: 32'h0000_0000,
        partial_remote: RST_TEMP,
        remote: RST_TEMP,
        local_temp: RST_TEMP,
        remote_high: RST_HIGH_LIMIT,
        remote_low: RST_LOW_LIMIT,
        local_high: RST_HIGH_LIMIT,
        local_low: RST_LOW_LIMIT,
        halt: 1'b0,
        rate: RST_RATE,
        flags: 4'h0,
        waitrequest: 1'b1,
        readdata: 32'h0000_0000,
        alert_oe_n: 1'b1,
        target_addr: TARGET_ADDR_BASE,
        addr_cnt: 3'h0,
        addr_done: 1'b0,
        adc_channel: 1'b0,
        adc_enable: 1'b0,
        data_oe_n: 1'b1
      };
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign avs_readdata = st.readdata;
  assign avs_waitrequest = st.waitrequest;
  // Both open-drain lines only ever pull low; the enables alone decide the wire.
  assign serial_data_line_out = 1'b0;
  assign serial_data_line_oe_n = st.data_oe_n;
  assign alert_out = 1'b0;
  assign alert_oe_n = st.alert_oe_n;
  assign adc_channel = st.adc_channel;
  assign adc_enable = st.adc_enable;
  assign target_address = st.target_addr;
endmodule

// *** testbench/temp_conv_properties.sv ***
// Concurrent checks on the ports of the conversion controller.
// Assumes it is bound to temp_conv_ctrl and shares its clock and synchronous reset.
`timescale 1ns/1ns
module temp_conv_properties
  import temp_conv_pkg::*;
#(
  parameter int CHANNEL_CYCLES = 20
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic hw_standby_input,
  input wire logic serial_data_line_oe_n,
  input wire logic alert_out,
  input wire logic alert_oe_n,
  input wire logic adc_channel,
  input wire logic adc_enable,
  input wire logic [6:0] target_address
);
  // --------------------------------------------------------------
  // Helper counters
  // --------------------------------------------------------------
  // Both counters saturate or clear, so a long run cannot wrap them.
  logic [15:0] en_cnt;
  logic [3:0] up_cnt;
  always_ff @(posedge mclk) begin
    if (reset) begin
      en_cnt <= 16'h0000;
      up_cnt <= 4'h0;
    end else begin
      en_cnt <= adc_enable ? en_cnt + 16'h0001 : 16'h0000;
      if (up_cnt != 4'hF) up_cnt <= up_cnt + 4'h1;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  // --------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------
  chk_bus_answer: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered after one wait");
  chk_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  chk_data_released: assert property (serial_data_line_oe_n)
    else $error("serial data line driven");
  chk_alert_never_high: assert property (!alert_oe_n |-> !alert_out)
    else $error("alert line driven high");
  chk_addr_frozen: assert property (up_cnt >= 4'h8 |-> $stable(target_address))
    else $error("target address changed after capture");
  chk_remote_first: assert property ($rose(adc_enable) |-> !adc_channel)
    else $error("conversion did not start on remote channel");
  chk_channel_switch: assert property (
    $rose(adc_channel) |-> adc_enable && en_cnt >= CHANNEL_CYCLES - 1
      && en_cnt <= CHANNEL_CYCLES + 1)
    else $error("channel switch at wrong time");
  chk_conv_bound: assert property (en_cnt <= 2 * CHANNEL_CYCLES + 1)
    else $error("conversion ran too long");
  chk_pin_abort: assert property (!hw_standby_input [*7] |-> !adc_enable)
    else $error("converting while standby pin low");
  chk_alert_at_end: assert property ($fell(alert_oe_n) |-> $fell(adc_enable))
    else $error("alert pulled low outside conversion end");
  chk_status_clear: assert property (
    avs_read && !avs_waitrequest && avs_address == OFS_STATUS && !adc_enable
      |=> alert_oe_n)
    else $error("status read did not release alert");
endmodule

// *** testbench/front_end_model.sv ***
// Behavioural analog front end: presents the selected channel's result.
// Assumes the bench sets the two channel values between conversions.
`timescale 1ns/1ns
module front_end_model (
  input wire logic mclk,
  input wire logic adc_channel,
  input wire logic adc_enable,
  input wire logic [7:0] remote_val,
  input wire logic [7:0] local_val,
  output logic [7:0] adc_result
);
  logic idle_pat = 1'b0;
  // Outside a conversion the result toggles, so a stale sample cannot pass.
  always_ff @(posedge mclk) idle_pat <= ~idle_pat;
  // One shared converter serves both channels.
  assign adc_result = !adc_enable ? {8{idle_pat}} : adc_channel ? local_val : remote_val;
endmodule

// *** testbench/tb.sv ***
// Self-checking bench for the conversion controller: bus tasks, scenarios, verdict.
// Assumes the front-end model and the property checker are compiled before it.
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin \
  $display("ERROR %s expected %h seen %h", nm, exp, got); fail_count++; end end
module tb;
  import temp_conv_pkg::*;
  localparam int CH = 20;
  localparam int RU = 50;
  logic mclk, reset, avs_read, avs_write, avs_waitrequest, hw_standby_input;
  logic address_select_low_pin, address_select_high_pin, serial_data_line_out;
  logic serial_data_line_oe_n, alert_out, alert_oe_n, adc_channel, adc_enable;
  logic [5:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [7:0] adc_result, remote_val, local_val;
  logic [6:0] target_address;
  wire sda = serial_data_line_oe_n ? 1'b1 : serial_data_line_out;
  wire alert_line = alert_oe_n ? 1'b1 : alert_out;
  int fail_count = 0, n_compared = 0, cyc = 0, t0;

  temp_conv_ctrl #(.CHANNEL_CYCLES(CH), .RATE_UNIT_CYCLES(RU)) dut (.mclk, .reset,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
    .hw_standby_input, .address_select_low_pin, .address_select_high_pin,
    .serial_clock_line(1'b1), .serial_data_line_in(sda), .serial_data_line_out,
    .serial_data_line_oe_n, .alert_out, .alert_oe_n, .adc_result, .adc_channel,
    .adc_enable, .target_address);
  front_end_model fe (.mclk, .adc_channel, .adc_enable, .remote_val, .local_val,
    .adc_result);

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk) cyc <= cyc + 1;

  // --------------------------------------------------------------
  // Bus and wait tasks
  // --------------------------------------------------------------
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0 && n < 50) begin
      @(posedge mclk);
      n++;
    end
    q = avs_readdata;
    if (n >= 50) fail_count++;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [5:0] a);
    bus(1'b0, a, 32'h0000_0000);
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic wait_en(input logic lvl, input int lim);
    int n;
    n = 0;
    while (adc_enable !== lvl && n < lim) begin
      @(posedge mclk);
      n++;
    end
    if (n >= lim) fail_count++;
  endtask

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_reset();
    logic [5:0] ofs[9] = '{OFS_REMOTE, OFS_LOCAL, OFS_RATE, OFS_REMOTE_HIGH, OFS_REMOTE_LOW,
      OFS_LOCAL_HIGH, OFS_LOCAL_LOW, OFS_ADDRESS, 6'h2C};
    logic [7:0] exp[9] = '{RST_TEMP, RST_TEMP, 8'(RST_RATE), RST_HIGH_LIMIT, RST_LOW_LIMIT,
      RST_HIGH_LIMIT, RST_LOW_LIMIT, 8'(TARGET_ADDR_BASE | 7'h02), 8'h00};
    rd(OFS_CONFIG);
    `CHK("halt", 32'h0000_0040, q)
    for (int i = 0; i < 9; i++) begin
      rd(ofs[i]);
      `CHK("reset value", {24'h00_0000, exp[i]}, q)
    end
    wr(OFS_ADDRESS, 32'h0000_0000);
    rd(OFS_ADDRESS);
    `CHK("address reg", 32'h0000_001A, q)
    address_select_high_pin <= 1'b0;
    address_select_low_pin <= 1'b1;
    repeat (10) @(posedge mclk);
    `CHK("address pins", 7'h1A, target_address)
  endtask

  task automatic t_conv();
    remote_val <= 8'h25;
    local_val <= 8'h1E;
    wr(OFS_ONESHOT, 32'h0000_0001);
    t0 = cyc;
    rd(OFS_STATUS);
    `CHK("busy", 1'b1, q[BIT_BUSY])
    rd(OFS_REMOTE);
    `CHK("old remote", 32'h0000_0000, q)
    wait_en(1'b0, 100);
    `CHK("conv time", 1'b1, (cyc - t0) inside {[2 * CH - 2 : 2 * CH + 2]})
    rd(OFS_REMOTE);
    `CHK("remote", 32'h0000_0025, q)
    rd(OFS_LOCAL);
    `CHK("local", 32'h0000_001E, q)
    rd(OFS_STATUS);
    `CHK("idle", 1'b0, q[BIT_BUSY])
    `CHK("no alarm", 1'b1, alert_line)
    `CHK("data released", 1'b1, sda)
  endtask

  task automatic t_alarm();
    wr(OFS_REMOTE_HIGH, 32'h0000_0020);
    wr(OFS_LOCAL_LOW, 32'h0000_0020);
    wr(OFS_ONESHOT, 32'h0000_0001);
    wait_en(1'b0, 100);
    `CHK("alert low", 1'b0, alert_line)
    rd(OFS_STATUS);
    `CHK("flags", 32'h0000_0012, q)
    `CHK("alert freed", 1'b1, alert_line)
  endtask

  task automatic t_pin_standby();
    remote_val <= 8'h40;
    local_val <= 8'h41;
    wr(OFS_ONESHOT, 32'h0000_0001);
    repeat (10) @(posedge mclk);
    hw_standby_input <= 1'b0;
    repeat (10) @(posedge mclk);
    `CHK("aborted", 1'b0, adc_enable)
    rd(OFS_REMOTE);
    `CHK("kept remote", 32'h0000_0025, q)
    rd(OFS_REMOTE_HIGH);
    `CHK("kept limit", 32'h0000_0020, q)
    wr(OFS_ONESHOT, 32'h0000_0001);
    repeat (5) @(posedge mclk);
    `CHK("pin blocks", 1'b0, adc_enable)
    hw_standby_input <= 1'b1;
    repeat (5) @(posedge mclk);
  endtask

  task automatic t_free_run();
    wr(OFS_RATE, 32'h0000_0001);
    wr(OFS_CONFIG, 32'h0000_0000);
    t0 = cyc;
    wait_en(1'b1, 400);
    `CHK("auto start", 1'b1, adc_enable)
    `CHK("rate period", 1'b1, (cyc - t0) inside {[2 * RU - 2 : 2 * RU + 4]})
    wait_en(1'b0, 100);
    rd(OFS_REMOTE);
    `CHK("auto result", 32'h0000_0040, q)
    remote_val <= 8'h33;
    wait_en(1'b1, 400);
    repeat (5) @(posedge mclk);
    wr(OFS_CONFIG, 32'h0000_0040);
    `CHK("halt abort", 1'b0, adc_enable)
    rd(OFS_REMOTE);
    `CHK("halt kept", 32'h0000_0040, q)
  endtask

  task automatic finish_test();
    $display("compared %0d mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    reset = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 6'h00;
    avs_writedata = 32'h0000_0000;
    hw_standby_input = 1'b1;
    address_select_high_pin = 1'b1;
    address_select_low_pin = 1'b0;
    remote_val = 8'h00;
    local_val = 8'h00;
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    wr(OFS_CONFIG, 32'h0000_0040);
    t_reset();
    t_conv();
    t_alarm();
    t_pin_standby();
    t_free_run();
    finish_test();
  end

  initial begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    finish_test();
  end
endmodule

bind temp_conv_ctrl temp_conv_properties #(.CHANNEL_CYCLES(CHANNEL_CYCLES)) props (.mclk,
  .reset, .avs_address, .avs_read, .avs_write, .avs_waitrequest, .hw_standby_input,
  .serial_data_line_oe_n, .alert_out, .alert_oe_n, .adc_channel, .adc_enable,
  .target_address);
